// >>> design/btc_pkg.sv
package btc_pkg;

  // ---------------------------------------------------------------
  // register map (6-bit host address)
  // ---------------------------------------------------------------
  localparam logic [5:0] BTC_ADR_AUX_CTRL   = 6'h04; // block a/b, +0x10 for c/d
  localparam logic [5:0] BTC_ADR_IRQ_FLAGS  = 6'h05; // read only
  localparam logic [5:0] BTC_ADR_RELOAD_HI  = 6'h06; // write reload, read count
  localparam logic [5:0] BTC_ADR_RELOAD_LO  = 6'h07; // write reload, read count
  localparam logic [5:0] BTC_ADR_START      = 6'h0E; // read only command
  localparam logic [5:0] BTC_ADR_STOP       = 6'h0F; // read only command
  localparam logic [5:0] BTC_ADR_RATE_EXT   = 6'h2D;
  localparam logic [5:0] BTC_ADR_DIV2_SET   = 6'h2E;
  localparam logic [5:0] BTC_ADR_DIV2_CLR   = 6'h2F;
  localparam logic [5:0] BTC_ADR_TEST_RATE  = 6'h39;
  localparam logic [5:0] BTC_ADR_BLK_MASK   = 6'h10; // block select bit
  localparam logic [5:0] BTC_ADR_BLK_LOCAL  = 6'h2F; // address with block bit removed

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         BTC_AUX_GROUP_BIT  = 7;
  localparam int         BTC_AUX_TIMER_BIT  = 6;
  localparam int         BTC_AUX_SRC_BIT    = 5;   // 1: internal clock, 0: pin
  localparam int         BTC_AUX_PRE_BIT    = 4;   // 1: source divided by 16
  localparam int         BTC_READY_BIT      = 3;
  localparam logic [7:0] BTC_AUX_RST        = 8'h60; // timer mode, internal clock
  localparam logic [7:0] BTC_RATE_EXT_RST   = 8'h00;
  localparam logic [7:0] BTC_TEST_RATE_RST  = 8'h00;
  localparam logic [7:0] BTC_RATE_ON        = 8'h01;
  localparam logic [15:0] BTC_RELOAD_RST    = 16'h0000;
  localparam logic [3:0] BTC_PRE_LAST       = 4'hF;

  // ---------------------------------------------------------------
  // clock selector codes, rate divisors
  // ---------------------------------------------------------------
  localparam int         BTC_DIV_W          = 13;
  localparam int         BTC_CHANNELS       = 4;
  localparam int         BTC_SELECTORS      = 8;  // rx and tx of each channel
  localparam logic [3:0] BTC_SEL_CTR        = 4'hD;
  localparam logic [3:0] BTC_SEL_EXT16      = 4'hE;
  localparam logic [3:0] BTC_SEL_EXT1       = 4'hF;

  typedef enum logic [1:0] {BTC_SRC_GEN, BTC_SRC_CTR, BTC_SRC_EXT} btc_src_t;

  // reference edges per 16x tick at the standard reference clock
  function automatic logic [BTC_DIV_W-1:0] btc_rate_div(input logic grp,
                                                          input logic [3:0] idx);
    logic [BTC_DIV_W-1:0] d;
    d = 13'h0001;
    unique case (idx)
      4'h0: d = grp ? 13'h0C00 : 13'h1200;  // 75 / 50
      4'h1: d = 13'h082F;                    // 110
      4'h2: d = 13'h06B1;                    // 134.5
      4'h3: d = grp ? 13'h0600 : 13'h0480;  // 150 / 200
      4'h4: d = 13'h0300;                    // 300
      4'h5: d = 13'h0180;                    // 600
      4'h6: d = 13'h00C0;                    // 1200
      4'h7: d = grp ? 13'h0073 : 13'h00DB;  // 2000 / 1050
      4'h8: d = 13'h0060;                    // 2400
      4'h9: d = 13'h0030;                    // 4800
      4'hA: d = grp ? 13'h0080 : 13'h0020;  // 1800 / 7200
      4'hB: d = 13'h0018;                    // 9600
      4'hC: d = grp ? 13'h000C : 13'h0006;  // 19200 / 38400
      default: d = 13'h0001;
    endcase
    return d;
  endfunction

endpackage

// >>> design/btc_clk_sel.sv
`timescale 1ns/10ps
module btc_clk_sel (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         ce_i,
  input  wire logic                         x1_tick_i,
  input  wire logic [btc_pkg::BTC_DIV_W-1:0] div_i,
  input  wire btc_pkg::btc_src_t            src_i,
  input  wire logic                         ctr_tick_i,
  input  wire logic                         ext_tick_i,
  output logic                              tick_o
);
  import btc_pkg::*;

  logic [BTC_DIV_W-1:0] cnt_q;
  logic [BTC_DIV_W-1:0] cnt_d;
  logic                 wrap;
  logic                 tick_d;

  // divider on the undivided reference, one pulse per div_i edges
  assign wrap   = (cnt_q >= div_i - 13'h0001);
  assign cnt_d  = !x1_tick_i ? cnt_q : (wrap ? '0 : cnt_q + 13'h0001);
  assign tick_d = (src_i == BTC_SRC_GEN) ? (x1_tick_i & wrap) :
                  (src_i == BTC_SRC_CTR) ? ctr_tick_i : ext_tick_i;

  // divider state and selected tick
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      cnt_q  <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule

// >>> design/btc_ctr.sv
`timescale 1ns/10ps
module btc_ctr (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        int_tick_i,
  input  wire logic        ext_tick_i,
  input  wire logic [7:0]  aux_i,
  input  wire logic [15:0] reload_i,
  input  wire logic        start_i,
  input  wire logic        stop_i,
  input  wire logic        timeout_en_i,
  input  wire logic        rx_load_i,
  output logic [15:0]      count_o,
  output logic             out_o,
  output logic             fall_o,
  output logic             rise_o
);
  import btc_pkg::*;

  logic [3:0]  pre_q;
  logic        run_q;
  logic        raw_tick;
  logic        src_tick;
  logic        timer;
  logic        restart;
  logic        halt;
  logic        terminal;
  logic [15:0] count_d;
  logic        out_d;
  logic        run_d;

  // clock source and optional /16 prescale
  assign raw_tick = aux_i[BTC_AUX_SRC_BIT] ? int_tick_i : ext_tick_i;
  assign src_tick = raw_tick & (!aux_i[BTC_AUX_PRE_BIT] || pre_q == BTC_PRE_LAST);

  // mode and command decode, receive data owns the counter in timeout
  assign timer    = aux_i[BTC_AUX_TIMER_BIT] & !timeout_en_i;
  assign restart  = timeout_en_i ? rx_load_i : start_i;
  assign halt     = !timeout_en_i & stop_i;
  assign terminal = (count_o == 16'h0001) || (timer && count_o == 16'h0000);

  // next count, output and run state
  always_comb begin
    count_d = count_o;
    out_d   = out_o;
    run_d   = run_q;
    if (restart) begin
      count_d = reload_i;
      out_d   = 1'b1;
      run_d   = 1'b1;
    end else if (timer) begin
      if (src_tick) begin
        if (terminal) begin
          count_d = reload_i;
          out_d   = !out_o;
        end else begin
          count_d = count_o - 16'h0001;
        end
      end
    end else if (halt) begin
      run_d = 1'b0;
      out_d = 1'b1;
    end else if (run_q && src_tick) begin
      count_d = count_o - 16'h0001;             // rolls over below zero
      if (terminal) begin
        out_d = 1'b0;
      end
    end
  end

  // state registers, output edge pulses
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q   <= '0;
      run_q   <= 1'b0;
      count_o <= BTC_RELOAD_RST;
      out_o   <= 1'b1;
      fall_o  <= 1'b0;
      rise_o  <= 1'b0;
    end else if (ce_i) begin
      pre_q   <= raw_tick ? pre_q + 4'h1 : pre_q;
      run_q   <= run_d;
      count_o <= count_d;
      out_o   <= out_d;
      fall_o  <= out_o & !out_d;
      rise_o  <= !out_o & out_d;
    end
  end
endmodule

// >>> design/btc_top.sv
`timescale 1ns/10ps
// Function
// - eighteen generator rates, 50 to 38400 baud
// - rate extension and test selects, reset 00
// - aux control bit 7 picks rate group
// - generator clocks run at sixteen times baud
// - halved clock everywhere except generator, detectors
// - generator rates scale with reference frequency
// - each rx and tx selects own clock
// - 16-bit divider: counter, timer, receive timeout
// - one independent divider per channel block
// - aux control bits 6:4 pick source, mode
// - divider output feeds baud and pins
// - falling divider output sets ready flag
// - start and stop by read, data ignored
// - start copies reload registers into counter
// - stop clears ready flag
// - timer square wave, half period reload
// - timer keeps setting ready after stop
// - writes select halved or normal clock
module btc_top (
  input  wire logic                                   CLK_SYS_I,
  input  wire logic                                   RESET_I,
  input  wire logic                                   CE_I,
  input  wire logic                                   X1_TICK_I,
  input  wire logic [5:0]                             ADDR_I,
  input  wire logic                                   RD_I,
  input  wire logic                                   WR_I,
  input  wire logic [7:0]                             DATA_I,
  input  wire logic [btc_pkg::BTC_SELECTORS-1:0][3:0] CLK_SEL_I,
  input  wire logic [btc_pkg::BTC_SELECTORS-1:0]      EXT_TICK_I,
  input  wire logic [1:0]                             CTR_EXT_I,
  input  wire logic [btc_pkg::BTC_CHANNELS-1:0]       TIMEOUT_EN_I,
  input  wire logic [btc_pkg::BTC_CHANNELS-1:0]       RX_LOAD_I,
  output logic [7:0]                                  DATA_O,
  output logic [btc_pkg::BTC_SELECTORS-1:0]           BAUD_TICK_O,
  output logic [1:0]                                  CTR_OUT_O,
  output logic [1:0]                                  READY_O,
  output logic                                        INT_TICK_O
);
  import btc_pkg::*;

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic [1:0][7:0]  aux_control_reg_q;
  logic [1:0][7:0]  reload_high_reg_q;
  logic [1:0][7:0]  reload_low_reg_q;
  logic [7:0]       rate_extension_select_q;
  logic [7:0]       test_rate_select_q;
  logic             div2_q;
  logic             half_q;

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  logic             blk;
  logic [5:0]       loc;
  logic [1:0]       blk_hit;
  logic [1:0]       wr_aux;
  logic [1:0]       wr_hi;
  logic [1:0]       wr_lo;
  logic [1:0]       start_cmd;
  logic [1:0]       stop_cmd;
  logic             wr_ext;
  logic             wr_test;
  logic             wr_div2_set;
  logic             wr_div2_clr;
  logic [7:0]       rd_data;

  // counter/timer wiring
  logic             int_tick;
  logic [1:0][15:0] count;
  logic [1:0]       ctr_out;
  logic [1:0]       ctr_fall;
  logic [1:0]       ctr_rise;
  logic [1:0]       blk_timeout;
  logic [1:0]       blk_rx_load;
  logic [1:0]       ready_clr;

  // block bit only meaningful in the lower half of the map
  assign blk = ADDR_I[4] & !ADDR_I[5];
  assign loc = ADDR_I[5] ? ADDR_I : (ADDR_I & BTC_ADR_BLK_LOCAL);

  // per-block strobes; start and stop look at address alone
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_blk_dec
      assign blk_hit[b]   = !ADDR_I[5] && (blk == b[0]);
      assign wr_aux[b]    = WR_I && blk_hit[b] && loc == BTC_ADR_AUX_CTRL;
      assign wr_hi[b]     = WR_I && blk_hit[b] && loc == BTC_ADR_RELOAD_HI;
      assign wr_lo[b]     = WR_I && blk_hit[b] && loc == BTC_ADR_RELOAD_LO;
      assign start_cmd[b] = RD_I && blk_hit[b] && loc == BTC_ADR_START;
      assign stop_cmd[b]  = RD_I && blk_hit[b] && loc == BTC_ADR_STOP;
    end
  endgenerate

  // global write strobes
  assign wr_ext      = WR_I && ADDR_I == BTC_ADR_RATE_EXT;
  assign wr_test     = WR_I && ADDR_I == BTC_ADR_TEST_RATE;
  assign wr_div2_set = WR_I && ADDR_I == BTC_ADR_DIV2_SET;
  assign wr_div2_clr = WR_I && ADDR_I == BTC_ADR_DIV2_CLR;

  // read data: flags, live count, test select; others read zero
  assign rd_data =
    (loc == BTC_ADR_IRQ_FLAGS && !ADDR_I[5]) ? (8'(READY_O[blk]) << BTC_READY_BIT) :
    (loc == BTC_ADR_RELOAD_HI && !ADDR_I[5]) ? count[blk][15:8] :
    (loc == BTC_ADR_RELOAD_LO && !ADDR_I[5]) ? count[blk][7:0] :
    (ADDR_I == BTC_ADR_TEST_RATE)             ? test_rate_select_q : 8'h00;

  // -----------------------------------------------------------------
  // host registers
  // -----------------------------------------------------------------
  // block registers written by the host
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      aux_control_reg_q <= {2{BTC_AUX_RST}};
      reload_high_reg_q <= {2{BTC_RELOAD_RST[15:8]}};
      reload_low_reg_q  <= {2{BTC_RELOAD_RST[7:0]}};
    end else if (CE_I) begin
      for (int i = 0; i < 2; i++) begin
        if (wr_aux[i]) begin
          aux_control_reg_q[i] <= DATA_I;
        end
        if (wr_hi[i]) begin
          reload_high_reg_q[i] <= DATA_I;
        end
        if (wr_lo[i]) begin
          reload_low_reg_q[i] <= DATA_I;
        end
      end
    end
  end

  // rate extension, test select and clock halving selects
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      rate_extension_select_q <= BTC_RATE_EXT_RST;
      test_rate_select_q      <= BTC_TEST_RATE_RST;
      div2_q                  <= 1'b0;
    end else if (CE_I) begin
      if (wr_ext) begin
        rate_extension_select_q <= DATA_I;
      end
      if (wr_test) begin
        test_rate_select_q <= DATA_I;
      end
      if (wr_div2_set) begin
        div2_q <= 1'b1;
      end else if (wr_div2_clr) begin
        div2_q <= 1'b0;
      end
    end
  end

  // read data register
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      DATA_O <= 8'h00;
    end else if (CE_I && RD_I) begin
      DATA_O <= rd_data;
    end
  end

  // -----------------------------------------------------------------
  // clock halving
  // -----------------------------------------------------------------
  // internal tick skips every other reference edge when halved
  assign int_tick = X1_TICK_I & (half_q | !div2_q);

  // phase toggle and halved clock tick for the rest of the chip
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      half_q     <= 1'b0;
      INT_TICK_O <= 1'b0;
    end else if (CE_I) begin
      half_q     <= X1_TICK_I ? !half_q : half_q;
      INT_TICK_O <= int_tick;
    end
  end

  // -----------------------------------------------------------------
  // counter/timers, one per block
  // -----------------------------------------------------------------
  generate
    for (b = 0; b < 2; b++) begin : g_ctr
      // any channel of the block in timeout mode owns the counter
      assign blk_timeout[b] = |TIMEOUT_EN_I[2*b +: 2];
      assign blk_rx_load[b] = |(RX_LOAD_I[2*b +: 2] & TIMEOUT_EN_I[2*b +: 2]);
      assign ready_clr[b]   = (stop_cmd[b] & !blk_timeout[b]) | blk_rx_load[b];

      btc_ctr u_ctr (
        .clk_i        (CLK_SYS_I),
        .rst_i        (RESET_I),
        .ce_i         (CE_I),
        .int_tick_i   (int_tick),
        .ext_tick_i   (CTR_EXT_I[b]),
        .aux_i        (aux_control_reg_q[b]),
        .reload_i     ({reload_high_reg_q[b], reload_low_reg_q[b]}),
        .start_i      (start_cmd[b]),
        .stop_i       (stop_cmd[b]),
        .timeout_en_i (blk_timeout[b]),
        .rx_load_i    (blk_rx_load[b]),
        .count_o      (count[b]),
        .out_o        (ctr_out[b]),
        .fall_o       (ctr_fall[b]),
        .rise_o       (ctr_rise[b])
      );
    end
  endgenerate

  // ready flags: a falling output wins over a same-cycle clear
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      READY_O   <= 2'b00;
      CTR_OUT_O <= 2'b11;
    end else if (CE_I) begin
      READY_O   <= ctr_fall | (READY_O & ~ready_clr);
      CTR_OUT_O <= ctr_out;
    end
  end

  // -----------------------------------------------------------------
  // rx and tx clock selectors
  // -----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < BTC_SELECTORS; s++) begin : g_sel
      logic [BTC_DIV_W-1:0] base_div;
      logic [BTC_DIV_W-1:0] ext_div;
      logic [BTC_DIV_W-1:0] sel_div;
      btc_src_t             src;

      // table divisor from the active group, then extensions
      assign base_div = btc_rate_div(aux_control_reg_q[s/4][BTC_AUX_GROUP_BIT],
                                     CLK_SEL_I[s]);
      assign ext_div  = (rate_extension_select_q == BTC_RATE_ON) ? (base_div >> 1) :
                        base_div;
      assign sel_div  = (test_rate_select_q == BTC_RATE_ON) ? (ext_div >> 2) : ext_div;
      assign src      = (CLK_SEL_I[s] == BTC_SEL_CTR) ? BTC_SRC_CTR :
                        (CLK_SEL_I[s] >= BTC_SEL_EXT16) ? BTC_SRC_EXT : BTC_SRC_GEN;

      btc_clk_sel u_sel (
        .clk_i      (CLK_SYS_I),
        .rst_i      (RESET_I),
        .ce_i       (CE_I),
        .x1_tick_i  (X1_TICK_I),
        .div_i      ((sel_div == '0) ? 13'h0001 : sel_div),
        .src_i      (src),
        .ctr_tick_i (ctr_rise[s/4]),
        .ext_tick_i (EXT_TICK_I[s]),
        .tick_o     (BAUD_TICK_O[s])
      );
    end
  endgenerate

endmodule

// >>> bench/btc_monitor.sv
`timescale 1ns/10ps
module btc_monitor (
  input wire logic                                   CLK_SYS_I,
  input wire logic                                   RESET_I,
  input wire logic                                   CE_I,
  input wire logic [5:0]                             ADDR_I,
  input wire logic                                   RD_I,
  input wire logic                                   WR_I,
  input wire logic [7:0]                             DATA_I,
  input wire logic [btc_pkg::BTC_SELECTORS-1:0][3:0] CLK_SEL_I,
  input wire logic [btc_pkg::BTC_SELECTORS-1:0]      EXT_TICK_I,
  input wire logic [btc_pkg::BTC_CHANNELS-1:0]       TIMEOUT_EN_I,
  input wire logic [7:0]                             DATA_O,
  input wire logic [btc_pkg::BTC_SELECTORS-1:0]      BAUD_TICK_O,
  input wire logic [1:0]                             CTR_OUT_O,
  input wire logic                                   INT_TICK_O
);
  import btc_pkg::*;
  // -------------------------------------------------------------
  // shadows of the host writes that the checks depend on
  // -------------------------------------------------------------
  logic [7:0] aux_a_q;
  logic [7:0] test_q;
  logic       div2_q;
  wire        rd_en = RD_I && CE_I;
  wire        wr_en = WR_I && CE_I;
  wire        cmd_a = (rd_en && ADDR_I inside {BTC_ADR_START, BTC_ADR_STOP}) ||
                      (wr_en && ADDR_I == BTC_ADR_AUX_CTRL);
  // track block a mode, test select and clock halving
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      aux_a_q <= BTC_AUX_RST;
      test_q  <= BTC_TEST_RATE_RST;
      div2_q  <= 1'b0;
    end else if (wr_en) begin
      if (ADDR_I == BTC_ADR_AUX_CTRL) aux_a_q <= DATA_I;
      if (ADDR_I == BTC_ADR_TEST_RATE) test_q <= DATA_I;
      if (ADDR_I == BTC_ADR_DIV2_SET) div2_q <= 1'b1;
      if (ADDR_I == BTC_ADR_DIV2_CLR) div2_q <= 1'b0;
    end
  end
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);
  // start command of block a while in counter mode
  sequence ctr_start_a;
    rd_en && ADDR_I == BTC_ADR_START && !aux_a_q[BTC_AUX_TIMER_BIT] && !TIMEOUT_EN_I[0];
  endsequence
  sequence out_high_soon;
    ##[1:3] CTR_OUT_O[0];
  endsequence
  chk_reset_values: assert property (disable iff (1'b0)
    RESET_I |-> DATA_O == 8'h00 && CTR_OUT_O == 2'b11 && BAUD_TICK_O == '0)
    else $error("outputs not at reset values");
  chk_unmapped_read: assert property (
    rd_en && ADDR_I[5:3] == 3'b111 && ADDR_I != BTC_ADR_TEST_RATE |=> DATA_O == 8'h00)
    else $error("reserved address read nonzero");
  chk_data_holds: assert property (
    !rd_en |=> $stable(DATA_O))
    else $error("read data changed without a read");
  chk_test_readback: assert property (
    rd_en && ADDR_I == BTC_ADR_TEST_RATE |=> DATA_O == test_q)
    else $error("test select read back wrong");
  chk_ext_passthru: assert property (
    CLK_SEL_I[2] == BTC_SEL_EXT16 && EXT_TICK_I[2] |-> ##[1:3] BAUD_TICK_O[2])
    else $error("external tick not passed to selector");
  chk_start_high: assert property (
    ctr_start_a |-> out_high_soon)
    else $error("counter output not high after start");
  chk_counter_low: assert property (
    !aux_a_q[BTC_AUX_TIMER_BIT] && !TIMEOUT_EN_I[0] && !CTR_OUT_O[0] && !cmd_a &&
    !$past(cmd_a) && !$past(cmd_a, 2) |=> !CTR_OUT_O[0])
    else $error("counter output rose without a command");
  chk_div2_tick: assert property (
    div2_q && $past(div2_q) && INT_TICK_O |=> !INT_TICK_O)
    else $error("internal tick not halved");
endmodule

// >>> bench/btc_host_model.sv
`timescale 1ns/10ps
module btc_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic [5:0]      addr_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic [7:0]      wdata_o
);
  // -------------------------------------------------------------
  // host side of the parallel register bus
  // -------------------------------------------------------------
  initial begin
    addr_o  = 6'h00;
    rd_o    = 1'b0;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
  end
  // write strobe for one edge, released lines scrambled
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  // read with junk on the data lines, answer taken after the edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= ~wdata_o;
    rd_o    <= 1'b1;
    @(posedge clk_i);
    rd_o    <= 1'b0;
    addr_o  <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule

// >>> bench/btc_testbench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
  cmp_count++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
  end \
end
module testbench;
  import btc_pkg::*;
  logic                          clk;
  logic                          rst;
  logic                          ce;
  logic                          x1;
  logic [BTC_SELECTORS-1:0][3:0] clk_sel;
  logic [BTC_SELECTORS-1:0]      ext_tick;
  logic [1:0]                    ctr_ext;
  logic [BTC_CHANNELS-1:0]       to_en;
  logic [BTC_CHANNELS-1:0]       rx_load;
  logic [5:0]                    addr;
  logic                          rd;
  logic                          wr;
  logic [7:0]                    wdata;
  logic [7:0]                    rdata;
  logic [BTC_SELECTORS-1:0]      baud;
  logic [1:0]                    ctr_out;
  logic                          int_tick;
  logic [8:0]                    ticks;
  int                            fail_count;
  int                            cmp_count;
  assign ticks = {int_tick, baud};
  btc_host u_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .rd_o(rd), .wr_o(wr),
                   .wdata_o(wdata));
  btc_top DUT (.CLK_SYS_I(clk), .RESET_I(rst), .CE_I(ce), .X1_TICK_I(x1), .ADDR_I(addr),
               .RD_I(rd), .WR_I(wr), .DATA_I(wdata), .CLK_SEL_I(clk_sel),
               .EXT_TICK_I(ext_tick), .CTR_EXT_I(ctr_ext), .TIMEOUT_EN_I(to_en),
               .RX_LOAD_I(rx_load), .DATA_O(rdata), .BAUD_TICK_O(baud),
               .CTR_OUT_O(ctr_out), .READY_O(), .INT_TICK_O(int_tick));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic tick(input int b);
    @(posedge clk);
    ctr_ext[b] <= 1'b1;
    @(posedge clk);
    ctr_ext[b] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] ex,
                        input string nm);
    logic [7:0] d;
    u_host.rd(a, d);
    `CHK(nm, ex, d & m)
  endtask
  // cycles between pulses, third one counted
  task automatic gap(input int idx, output int n);
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (ticks[idx] !== 1'b1 && n < 300);
    end
  endtask
  task automatic gap_chk(input int idx, input int ex, input string nm);
    int n;
    gap(idx, n);
    `CHK(nm, ex, n)
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_regs;
    rd_chk(BTC_ADR_TEST_RATE, 8'hFF, BTC_TEST_RATE_RST, "test reset");
    u_host.wr(BTC_ADR_TEST_RATE, BTC_RATE_ON);
    rd_chk(BTC_ADR_TEST_RATE, 8'hFF, BTC_RATE_ON, "test on");
    u_host.wr(BTC_ADR_TEST_RATE, 8'h00);
    rd_chk(6'h3A, 8'hFF, 8'h00, "unmapped");
    rd_chk(BTC_ADR_RATE_EXT, 8'hFF, 8'h00, "ext write only");
  endtask
  task automatic t_counter;
    logic [7:0] d;
    u_host.wr(BTC_ADR_AUX_CTRL, 8'h00);
    u_host.wr(BTC_ADR_AUX_CTRL | BTC_ADR_BLK_MASK, 8'h00);
    u_host.rd(BTC_ADR_STOP, d);
    u_host.rd(BTC_ADR_STOP | BTC_ADR_BLK_MASK, d);
    u_host.wr(BTC_ADR_RELOAD_HI, 8'h00);
    u_host.wr(BTC_ADR_RELOAD_LO, 8'h03);
    u_host.rd(BTC_ADR_START, d);
    tick(0);
    rd_chk(BTC_ADR_RELOAD_LO, 8'hFF, 8'h02, "count lo");
    rd_chk(BTC_ADR_RELOAD_HI, 8'hFF, 8'h00, "count hi");
    `CHK("out counting", 2'b11, ctr_out)
    tick(0);
    tick(0);
    `CHK("out at end", 2'b10, ctr_out)
    rd_chk(BTC_ADR_IRQ_FLAGS, 8'h08, 8'h08, "ready a");
    `CHK("ready pin", 2'b01, DUT.READY_O)
    rd_chk(BTC_ADR_IRQ_FLAGS | BTC_ADR_BLK_MASK, 8'h08, 8'h00, "ready b");
    u_host.rd(BTC_ADR_STOP, d);
    rd_chk(BTC_ADR_IRQ_FLAGS, 8'h08, 8'h00, "ready stop");
    `CHK("out stopped", 2'b11, ctr_out)
  endtask
  task automatic t_timer;
    int         tg;
    logic       pv;
    logic [7:0] d;
    tg = 0;
    u_host.wr(BTC_ADR_AUX_CTRL, 8'h40);
    u_host.wr(BTC_ADR_RELOAD_LO, 8'h02);
    u_host.rd(BTC_ADR_START, d);
    repeat (3) @(posedge clk);
    pv = ctr_out[0];
    for (int i = 0; i < 12; i++) begin
      if (i == 8) begin
        `CHK("toggles", 4, tg)
        u_host.rd(BTC_ADR_STOP, d);
        rd_chk(BTC_ADR_IRQ_FLAGS, 8'h08, 8'h00, "stop clears");
      end
      tick(0);
      tg += int'(ctr_out[0] !== pv);
      pv = ctr_out[0];
    end
    `CHK("toggles after stop", 6, tg)
    rd_chk(BTC_ADR_IRQ_FLAGS, 8'h08, 8'h08, "ready after stop");
  endtask
  task automatic t_baud;
    int g;
    int h;
    @(posedge clk);
    clk_sel[0] <= 4'hC;
    clk_sel[1] <= 4'hB;
    clk_sel[2] <= BTC_SEL_EXT16;
    u_host.wr(BTC_ADR_AUX_CTRL, 8'h40);
    gap_chk(0, 6, "rate c grp0");
    gap_chk(1, 24, "rate b");
    u_host.wr(BTC_ADR_AUX_CTRL, 8'hC0);
    gap_chk(0, 12, "rate c grp1");
    u_host.wr(BTC_ADR_RATE_EXT, BTC_RATE_ON);
    gap_chk(1, 12, "rate ext");
    u_host.wr(BTC_ADR_RATE_EXT, 8'h00);
    u_host.wr(BTC_ADR_TEST_RATE, BTC_RATE_ON);
    gap_chk(1, 6, "rate test");
    u_host.wr(BTC_ADR_TEST_RATE, 8'h00);
    gap(8, g);
    u_host.wr(BTC_ADR_DIV2_SET, 8'h00);
    gap(8, h);
    `CHK("halved tick", 2 * g, h)
    gap_chk(0, 12, "rate kept");
    u_host.wr(BTC_ADR_DIV2_CLR, 8'h00);
    gap_chk(8, g, "normal tick");
    @(posedge clk);
    ext_tick[2] <= 1'b1;
    h = 0;
    repeat (4) begin
      @(posedge clk);
      ext_tick[2] <= 1'b0;
      #1;
      h += int'(baud[2]);
    end
    `CHK("ext pass", 1, h)
  endtask
  // -------------------------------------------------------------
  // clock, main sequence, watchdog
  // -------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    rst <= 1'b1;
    ce = 1'b1;
    x1 = 1'b1;
    clk_sel = '0;
    ext_tick = '0;
    ctr_ext = '0;
    to_en = '0;
    rx_load = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_counter();
    t_timer();
    t_baud();
    report_and_stop();
  end
  initial begin
    #500000;
    fail_count++;
    report_and_stop();
  end
endmodule
bind btc_top btc_monitor u_mon (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .CE_I(CE_I),
  .ADDR_I(ADDR_I), .RD_I(RD_I), .WR_I(WR_I), .DATA_I(DATA_I), .CLK_SEL_I(CLK_SEL_I),
  .EXT_TICK_I(EXT_TICK_I), .TIMEOUT_EN_I(TIMEOUT_EN_I), .DATA_O(DATA_O),
  .BAUD_TICK_O(BAUD_TICK_O), .CTR_OUT_O(CTR_OUT_O), .INT_TICK_O(INT_TICK_O));
